//--- core/stb_buffer_status.sv
// transmit/receive buffering and status of a serial interface controller
// assumes a shifter that takes words on tx_load and reports rx words and
// errors with one-cycle pulses; registers reached over axi4-lite
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

// Function
// R1 - host write goes straight to shift register when it is empty
// R2 - write while shifter busy is kept in holding buffer until it frees
// R3 - host sets global enable before writing transmit data register
// R4 - clearing global enable forces the transmit word to zero
// R5 - host right-justifies the transmit word in the 16-bit field
// R6 - reading the receive buffer register sets the empty flag
// R7 - a received word copied into receive buffer clears empty flag
// R8 - write-one clearing receive interrupt flag also sets empty flag
// R9 - reading receive buffer register clears receive interrupt flag
// R10 - word arriving when holding buffer is full sets overrun
// R11 - overrun overwrites only holding buffer, never visible buffer
// R12 - reading receive buffer register leaves overrun flag unchanged
// R13 - each read moves a full holding buffer into the visible buffer
// R14 - error while both buffers full also sets overrun; code counts only bit, timeout and length errors
// R15 - transmit full sets on write while busy, clears on move to shifter
// R16 - bit mismatch flag clears when receive word is read
// R17 - received word right-justified, reserved bits read zero
module stb_buffer_status
  import stb_pkg::*;
#(
  parameter int WORD_W = STB_WORD_W
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // shifter side
  output logic             tx_load,
  output logic [WORD_W-1:0] tx_word,
  input  wire logic        tx_shift_free,
  input  wire stb_shift_rx_t rx_in,
  input  wire stb_err_t    rx_err_evt,
  // enable and interrupt
  output logic             enable,
  output logic             irq
);

  // all state in one struct
  typedef struct packed {
    logic                      en;
    logic [WORD_W-1:0]         tx_data;
    logic                      shift_full;
    logic                      hold_full;
    logic [WORD_W-1:0]         hold_word;
    logic                      load;
    logic [WORD_W-1:0]         load_word;
    logic                      vis_empty;
    stb_err_t                  vis_err;
    logic [WORD_W-1:0]         vis_word;
    stb_rx_slot_t              rxh;
    logic                      rx_ovr;
    logic [STB_FLG_W-1:0]      flag;
    logic [STB_FLG_W-1:0]      mask;
    logic                      irq;
  } stb_state_t;

  stb_state_t st_ff;
  stb_state_t nxt_st;

  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_stb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;

  stb_axil_slave u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_err    (wr_err),
    .rd_stb    (rd_stb),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_err    (rd_err)
  );

  // decoded accesses
  logic wr_txd;
  logic wr_gcr;
  logic wr_flg;
  logic wr_msk;
  logic rd_buf;
  logic rd_word;
  logic any_err;
  logic ovr_evt;

  // address decode for writes and reads
  always_comb begin
    wr_txd = 1'b0;
    wr_gcr = 1'b0;
    wr_flg = 1'b0;
    wr_msk = 1'b0;
    wr_err = 1'b0;
    if (wr_addr == STB_OFS_TX_DATA_CTRL)
      wr_txd = wr_stb;
    else if (wr_addr == STB_OFS_GLOBAL_CTRL)
      wr_gcr = wr_stb;
    else if (wr_addr == STB_OFS_FLAG)
      wr_flg = wr_stb;
    else if (wr_addr == STB_OFS_IRQ_MASK)
      wr_msk = wr_stb;
    else if (wr_addr != STB_OFS_RX_BUF)
      wr_err = wr_stb;
  end

  // a read counts as a word read when it covers the low half; axi4-lite
  // reads are always whole words, so every buffer read does
  assign rd_buf  = rd_stb && (rd_addr == STB_OFS_RX_BUF);
  assign rd_word = rd_buf;
  assign any_err = rx_err_evt.bit_err | rx_err_evt.timeout |
                   rx_err_evt.len_err;

  // read data mux; reserved bits and unused word bits stay zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (rd_addr == STB_OFS_RX_BUF) begin
      rd_data[STB_BIT_RX_EMPTY] = st_ff.vis_empty;
      rd_data[STB_BIT_RX_OVR]   = st_ff.rx_ovr;
      rd_data[STB_BIT_TX_FULL]  = st_ff.hold_full;
      rd_data[STB_BIT_BIT_ERR:STB_BIT_LEN_ERR] = st_ff.vis_err;
      rd_data[WORD_W-1:0]       = st_ff.vis_word; // R17
    end else if (rd_addr == STB_OFS_TX_DATA_CTRL) begin
      rd_data[WORD_W-1:0] = st_ff.tx_data;
    end else if (rd_addr == STB_OFS_GLOBAL_CTRL) begin
      rd_data[STB_GCR_ENABLE] = st_ff.en;
    end else if (rd_addr == STB_OFS_FLAG) begin
      rd_data[STB_FLG_W-1:0] = st_ff.flag;
    end else if (rd_addr == STB_OFS_IRQ_MASK) begin
      rd_data[STB_FLG_W-1:0] = st_ff.mask;
    end else begin
      rd_err = 1'b1;
    end
  end

  // next-state logic: transmit path, receive path, flags
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.load = 1'b0;
    ovr_evt     = 1'b0;

    // global enable; dropping it zeroes the transmit word
    if (wr_gcr && wr_strb[0])
      nxt_st.en = wr_data[STB_GCR_ENABLE];
    if (wr_gcr && wr_strb[0] && !wr_data[STB_GCR_ENABLE])
      nxt_st.tx_data = STB_RST_WORD; // R4

    // shifter releases its word
    if (tx_shift_free)
      nxt_st.shift_full = 1'b0;

    // holding buffer drains into a free shifter
    if (st_ff.hold_full && !nxt_st.shift_full) begin
      nxt_st.hold_full  = 1'b0; // R15
      nxt_st.shift_full = 1'b1;
      nxt_st.load       = 1'b1;
      nxt_st.load_word  = st_ff.hold_word; // R2
    end

    // host write of the transmit word; the host enables first, so a
    // write while disabled is dropped rather than queued
    if (wr_txd && st_ff.en && (wr_strb[1:0] != 2'b00)) begin // R3
      if (wr_strb[0])
        nxt_st.tx_data[7:0] = wr_data[7:0];
      if (wr_strb[1])
        nxt_st.tx_data[WORD_W-1:8] = wr_data[WORD_W-1:8];
      if (!nxt_st.shift_full && !nxt_st.load) begin
        nxt_st.shift_full = 1'b1; // R1
        nxt_st.load       = 1'b1;
        nxt_st.load_word  = nxt_st.tx_data;
      end else begin
        nxt_st.hold_full = 1'b1; // R15
        nxt_st.hold_word = nxt_st.tx_data; // R2
      end
    end

    // host read of the buffer: empty set, interrupt flag dropped,
    // overrun untouched, error flags of the word dropped
    if (rd_word) begin // R12
      nxt_st.vis_empty              = 1'b1; // R6
      nxt_st.flag[STB_FLG_RX_INT]   = 1'b0; // R9
      nxt_st.vis_err.bit_err        = 1'b0; // R16
      nxt_st.vis_err.desync         = 1'b0;
      nxt_st.vis_err.par_err        = 1'b0;
      nxt_st.vis_err.timeout        = 1'b0;
      nxt_st.vis_err.len_err        = 1'b0;
    end
    // a read pulls a waiting word forward
    if (rd_buf && st_ff.rxh.full) begin
      nxt_st.vis_word  = st_ff.rxh.word; // R13
      nxt_st.vis_err   = st_ff.rxh.err;
      nxt_st.vis_empty = 1'b0;
      nxt_st.rxh.full  = 1'b0;
    end

    // flag write-one-to-clear; discard of the pending word
    if (wr_flg && wr_strb[0]) begin
      nxt_st.flag = nxt_st.flag & ~wr_data[STB_FLG_W-1:0];
      if (wr_data[STB_FLG_RX_INT])
        nxt_st.vis_empty = 1'b1; // R8
      if (wr_data[STB_FLG_RX_OVR])
        nxt_st.rx_ovr = 1'b0;
    end
    if (wr_msk && wr_strb[0])
      nxt_st.mask = wr_data[STB_FLG_W-1:0];

    // completed reception; set wins over any clear in this cycle
    if (rx_in.done) begin
      if (nxt_st.vis_empty && !nxt_st.rxh.full) begin
        nxt_st.vis_word  = rx_in.word; // R7
        nxt_st.vis_err   = rx_in.err;
        nxt_st.vis_empty = 1'b0; // R7
      end else begin
        // visible word is kept until read; only the holder is replaced
        if (nxt_st.rxh.full) begin
          nxt_st.rx_ovr = 1'b1; // R10
          ovr_evt       = 1'b1;
        end
        nxt_st.rxh.full = 1'b1; // R11
        nxt_st.rxh.word = rx_in.word;
        nxt_st.rxh.err  = rx_in.err;
      end
      nxt_st.flag[STB_FLG_RX_INT] = 1'b1;
    end

    // error while both buffers hold unread words means status is lost
    if (any_err && !st_ff.vis_empty && st_ff.rxh.full) begin
      nxt_st.rx_ovr = 1'b1; // R14
      ovr_evt       = 1'b1;
    end
    // keyed to the event, so a same-cycle write-one clear cannot hide it
    if (ovr_evt)
      nxt_st.flag[STB_FLG_RX_OVR] = 1'b1;
    if (any_err)
      nxt_st.flag[STB_FLG_ERR] = 1'b1;

    nxt_st.irq = |(nxt_st.flag & nxt_st.mask);
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff           <= '0;
      st_ff.vis_empty <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign tx_load = st_ff.load;
  assign tx_word = st_ff.load_word; // R5
  assign enable  = st_ff.en;
  assign irq     = st_ff.irq;

endmodule : stb_buffer_status

//--- core/stb_pkg.sv
// package for the serial data-path buffering and status block
// assumes one 100 MHz clock and an axi4-lite register bus of 32-bit data
package stb_pkg;

  // register byte offsets
  localparam logic [7:0] STB_OFS_TX_DATA_CTRL = 8'h00;
  localparam logic [7:0] STB_OFS_RX_BUF       = 8'h04;
  localparam logic [7:0] STB_OFS_GLOBAL_CTRL  = 8'h08;
  localparam logic [7:0] STB_OFS_FLAG         = 8'h0c;
  localparam logic [7:0] STB_OFS_IRQ_MASK     = 8'h10;

  // receive buffer register field positions
  localparam int STB_BIT_RX_EMPTY = 31;
  localparam int STB_BIT_RX_OVR   = 30;
  localparam int STB_BIT_TX_FULL  = 29;
  localparam int STB_BIT_BIT_ERR  = 28;
  localparam int STB_BIT_DESYNC   = 27;
  localparam int STB_BIT_PAR_ERR  = 26;
  localparam int STB_BIT_TIMEOUT  = 25;
  localparam int STB_BIT_LEN_ERR  = 24;
  localparam int STB_WORD_W       = 16;

  // flag register / mask register bit positions
  localparam int STB_FLG_RX_INT  = 0;
  localparam int STB_FLG_RX_OVR  = 1;
  localparam int STB_FLG_ERR     = 2;
  localparam int STB_FLG_W       = 3;

  // global control bit position
  localparam int STB_GCR_ENABLE  = 0;

  // reset values
  localparam logic [15:0] STB_RST_WORD  = 16'h0000;
  localparam logic [7:0]  STB_RST_STAT  = 8'h00;

  // axi responses
  localparam logic [1:0] STB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] STB_RESP_SLVERR = 2'h2;

  // error status carried with each received word (bits 28..24)
  typedef struct packed {
    logic bit_err;
    logic desync;
    logic par_err;
    logic timeout;
    logic len_err;
  } stb_err_t;

  // one received word with its status
  typedef struct packed {
    logic                  full;
    stb_err_t              err;
    logic [STB_WORD_W-1:0] word;
  } stb_rx_slot_t;

  // shifter side signals
  typedef struct packed {
    logic                  done;
    logic [STB_WORD_W-1:0] word;
    stb_err_t              err;
  } stb_shift_rx_t;

endpackage : stb_pkg

//--- core/stb_axil_slave.sv
// axi4-lite slave front end: turns channel handshakes into single-cycle
// read and write strobes; assumes the main block answers in the same cycle
`timescale 1ns/1ps
module stb_axil_slave
  import stb_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi write channels
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi read channels
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // register side
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic             rd_stb,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);

  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  aw;
    logic        w_ok;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } stb_axs_t;

  stb_axs_t st_ff;
  stb_axs_t nxt_st;

  // address and data are latched separately, so either may come first
  always_comb begin
    nxt_st = st_ff;
    if (s_awvalid && s_awready) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.aw    = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.wd   = s_wdata;
      nxt_st.ws   = s_wstrb;
    end
    if (wr_stb) begin
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = wr_err ? STB_RESP_SLVERR : STB_RESP_OKAY;
    end
    if (s_bvalid && s_bready)
      nxt_st.bvalid = 1'b0;
    if (rd_stb) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_data;
      nxt_st.rresp  = rd_err ? STB_RESP_SLVERR : STB_RESP_OKAY;
    end else if (s_rvalid && s_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // write fires once both halves are held and no response is pending
  assign wr_stb    = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;
  assign wr_addr   = st_ff.aw;
  assign wr_data   = st_ff.wd;
  assign wr_strb   = st_ff.ws;
  assign rd_stb    = s_arvalid && !st_ff.rvalid;
  assign rd_addr   = s_araddr;
  assign s_awready = !st_ff.aw_ok;
  assign s_wready  = !st_ff.w_ok;
  assign s_arready = !st_ff.rvalid;
  assign s_bvalid  = st_ff.bvalid;
  assign s_bresp   = st_ff.bresp;
  assign s_rvalid  = st_ff.rvalid;
  assign s_rdata   = st_ff.rdata;
  assign s_rresp   = st_ff.rresp;

endmodule : stb_axil_slave

//--- bench/stb_chk_assertions.sv
// checker for the buffering block: bus answers, tx hand-off, rx status
// assumes binding onto stb_buffer_status, one clock domain
`timescale 1ns/1ps
module stb_chk
  import stb_pkg::*;
#(
  parameter int WORD_W = STB_WORD_W
) (
  // clock and reset
  input logic              aclk,
  input logic              aresetn,
  // register bus
  input logic [7:0]        s_awaddr,
  input logic              s_awvalid,
  input logic              s_awready,
  input logic [31:0]       s_wdata,
  input logic [3:0]        s_wstrb,
  input logic              s_wvalid,
  input logic              s_wready,
  input logic              s_bvalid,
  input logic [7:0]        s_araddr,
  input logic              s_arvalid,
  input logic              s_arready,
  input logic [31:0]       s_rdata,
  input logic [1:0]        s_rresp,
  input logic              s_rvalid,
  input logic              s_rready,
  // shifter and status
  input logic              tx_load,
  input logic [WORD_W-1:0] tx_word,
  input logic              tx_shift_free,
  input logic              enable,
  input logic              irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [7:0]        ra_ff;
  logic              busy_ff;
  logic              ovr_ff;
  logic [WORD_W-1:0] wd_ff;
  wire aw_hs = s_awvalid && s_awready;
  wire w_hs  = s_wvalid && s_wready;
  wire rd_rx = s_rvalid && ra_ff == STB_OFS_RX_BUF;

  // read address in flight, shifter occupancy, overrun seen by a read;
  // any flag write forgets overrun, which only weakens the check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra_ff   <= 8'h00;
      busy_ff <= 1'b0;
      ovr_ff  <= 1'b0;
      wd_ff   <= '0;
    end else begin
      if (s_arvalid && s_arready) ra_ff <= s_araddr;
      if (w_hs) wd_ff <= s_wdata[WORD_W-1:0];
      if (tx_load) busy_ff <= 1'b1;
      else if (tx_shift_free) busy_ff <= 1'b0;
      if (aw_hs && s_awaddr == STB_OFS_FLAG) ovr_ff <= 1'b0;
      else if (rd_rx && s_rready && s_rdata[30]) ovr_ff <= 1'b1;
    end
  end

  sequence s_tx_wr;
    aw_hs && w_hs && s_awaddr == STB_OFS_TX_DATA_CTRL && s_wstrb == 4'hf
      && enable && !busy_ff && !tx_load;
  endsequence

  a_reset_quiet: assert property ($rose(aresetn) |-> !tx_load && !irq
    && !enable && !s_bvalid && !s_rvalid) else $error("not idle at reset");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_rvalid && !s_rready |=>
    s_rvalid && $stable(s_rdata)) else $error("read data dropped");
  a_write_answer: assert property (aw_hs && w_hs |-> ##[1:3] s_bvalid)
    else $error("write answer late");
  a_resp_code: assert property (s_rvalid |-> s_rresp ==
    ((ra_ff > 8'h10 || ra_ff[1:0] != 2'b00) ? STB_RESP_SLVERR :
    STB_RESP_OKAY)) else $error("bad read response");
  a_rsvd_zero:
    assert property (rd_rx |-> s_rdata[23:16] == 8'h00)
    else $error("reserved bits set");
  a_ovr_sticky:
    assert property (rd_rx && ovr_ff |-> s_rdata[30])
    else $error("overrun lost on read");
  a_tx_direct:
    assert property (s_tx_wr |-> ##[1:4] (tx_load && tx_word == wd_ff))
    else $error("word not passed to shifter");
endmodule : stb_chk

bind stb_buffer_status stb_chk #(.WORD_W(WORD_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
  .s_wready(s_wready), .s_bvalid(s_bvalid),
  .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
  .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
  .s_rready(s_rready),
  .tx_load(tx_load), .tx_word(tx_word), .tx_shift_free(tx_shift_free),
  .enable(enable), .irq(irq)
);

//--- bench/stb_shift_model.sv
// behavioural shifter: takes words on tx_load, frees after a delay,
// sends received words and error pulses when the bench asks
`timescale 1ns/1ps
module stb_shift_model
  import stb_pkg::*;
#(
  parameter int DLY = 20
) (
  // clock
  input  logic                  aclk,
  // transmit
  input  logic                  tx_load,
  input  logic [STB_WORD_W-1:0] tx_word,
  output logic                  tx_shift_free,
  // receive
  output stb_shift_rx_t         rx_in,
  output stb_err_t              rx_err_evt
);
  logic [15:0] last_word = 16'h0000;
  int          loads     = 0;
  int          cnt       = 0;

  initial begin
    tx_shift_free = 1'b0;
    rx_in = '0;
    rx_err_evt = '0;
  end

  // shift each word for DLY cycles, then free the register once
  always @(posedge aclk) begin
    tx_shift_free <= cnt == 1;
    if (tx_load) begin
      last_word <= tx_word;
      loads <= loads + 1;
      cnt <= DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  // one reception; lines flip after done so stale data never matches
  task automatic send(input logic [15:0] w, input stb_err_t e);
    @(posedge aclk);
    rx_in <= '{1'b1, w, e};
    @(posedge aclk);
    rx_in <= '{1'b0, ~w, ~e};
  endtask : send

  task automatic fault(input stb_err_t e);
    @(posedge aclk);
    rx_err_evt <= e;
    @(posedge aclk);
    rx_err_evt <= '0;
  endtask : fault
endmodule : stb_shift_model

//--- bench/testbench.sv
// self-checking bench for the buffering block over axi4-lite
// assumes stb_shift_model as shifter and the checker bound in
`timescale 1ns/1ps
module testbench;
  import stb_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] m;
    logic [31:0] e;
    logic [1:0]  r;
  } stb_row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, d;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
  logic s_rready = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic tx_load, tx_shift_free, enable, irq;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [15:0] tx_word;
  stb_shift_rx_t rx_in;
  stb_err_t rx_err_evt;
  int fail_count = 0, num_checks = 0, cyc = 0;
  stb_row_t rows [5] = '{
    '{8'h04, 32'hffffffff, 32'h80000000, STB_RESP_OKAY},
    '{8'h08, 32'hffffffff, 32'h0, STB_RESP_OKAY},
    '{8'h0c, 32'hffffffff, 32'h0, STB_RESP_OKAY},
    '{8'h10, 32'hffffffff, 32'h0, STB_RESP_OKAY},
    '{8'h14, 32'h0, 32'h0, STB_RESP_SLVERR}};

  stb_buffer_status dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .tx_load(tx_load), .tx_word(tx_word), .tx_shift_free(tx_shift_free),
    .rx_in(rx_in), .rx_err_evt(rx_err_evt),
    .enable(enable), .irq(irq)
  );
  stb_shift_model u_shift (
    .aclk(aclk), .tx_load(tx_load), .tx_word(tx_word),
    .tx_shift_free(tx_shift_free), .rx_in(rx_in), .rx_err_evt(rx_err_evt)
  );

  initial forever #5 aclk = ~aclk;

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic ck(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : ck

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    v = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask : rd

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      ck("reset value", rows[i].e, d & rows[i].m);
      ck("response", {30'h0, rows[i].r}, {30'h0, rsp});
    end
    // transmit: ignored while disabled, direct, then held while busy
    wr(8'h00, 32'h1234);
    repeat (3) @(posedge aclk);
    ck("loads idle", 32'h0, 32'(u_shift.loads));
    wr(8'h08, 32'h1);
    ck("enable on", 32'h1, {31'h0, enable});
    ck("write okay", {30'h0, STB_RESP_OKAY}, {30'h0, rsp});
    wr(8'h00, 32'ha5c3);
    repeat (3) @(posedge aclk);
    ck("tx direct", 32'ha5c3, {16'h0, u_shift.last_word});
    wr(8'h00, 32'h5a3c);
    rd(8'h04, d);
    ck("tx full set", 32'h1, {31'h0, d[29]});
    repeat (24) @(posedge aclk);
    ck("tx held", 32'h5a3c, {16'h0, u_shift.last_word});
    rd(8'h04, d);
    ck("tx full clr", 32'h0, {31'h0, d[29]});
    wr(8'h08, 32'h0);
    ck("enable off", 32'h0, {31'h0, enable});
    rd(8'h00, d);
    ck("tx cleared", 32'h0, {16'h0, d[15:0]});
    // receive with interrupt, read, discard
    wr(8'h10, 32'h1);
    u_shift.send(16'h00c3, '0);
    repeat (2) @(posedge aclk);
    ck("irq set", 32'h1, {31'h0, irq});
    rd(8'h04, d);
    ck("rx word", 32'h000000c3, d);
    repeat (2) @(posedge aclk);
    ck("irq read", 32'h0, {31'h0, irq});
    rd(8'h04, d);
    ck("empty read", 32'h80000000, d & 32'h80000000);
    u_shift.send(16'h0011, '0);
    wr(8'h0c, 32'h1);
    rd(8'h04, d);
    ck("discard", 32'h80000000, d & 32'h80000000);
    ck("irq discard", 32'h0, {31'h0, irq});
    // bit mismatch flag shown once, cleared by the read
    u_shift.send(16'h0077, 5'h10);
    rd(8'h04, d);
    ck("bit err", 32'h10000077, d);
    rd(8'h04, d);
    ck("bit err clr", 32'h80000000, d & 32'h90000000);
    // three words, no read: third overwrites the holding buffer only
    u_shift.send(16'h0001, '0);
    u_shift.send(16'h0002, '0);
    u_shift.send(16'h0003, '0);
    rd(8'h04, d);
    ck("overrun 1", 32'h40000001, d);
    rd(8'h04, d);
    ck("overrun 2", 32'h40000003, d);
    wr(8'h0c, 32'h2);
    rd(8'h04, d);
    ck("overrun clr", 32'h80000000, d & 32'hc0000000);
    // error while both buffers hold words
    u_shift.send(16'h0004, '0);
    u_shift.send(16'h0005, '0);
    u_shift.fault(5'h02);
    rd(8'h04, d);
    ck("overrun err", 32'h40000000, d & 32'h40000000);
    rd(8'h0c, d);
    ck("flags after err", 32'h6, d);
    wr(8'h14, 32'h1);
    ck("write slverr", {30'h0, STB_RESP_SLVERR}, {30'h0, rsp});
    stop_test();
  end
endmodule : testbench
